// ==== warf_map.vh ====
`ifndef WARF_MAP_VH
`define WARF_MAP_VH

// ==========================================================
// register addresses
`define WARF_RCS_DATA_OFS  8'h54
`define WARF_IO_SHIFT      8'h20
`define WARF_RCS_IO_OFS    8'h34
`define WARF_WCS_DATA_OFS  8'h60

// ==========================================================
// reset_cause_status fields
`define WARF_RCS_WDOG      3
`define WARF_RCS_BROWN     2
`define WARF_RCS_PIN       1
`define WARF_RCS_PWRON     0
`define WARF_RCS_RESET     4'h0

// ==========================================================
// watchdog_control_status fields
`define WARF_WCS_IRQF      7
`define WARF_WCS_IRQE      6
`define WARF_WCS_PMSB      5
`define WARF_WCS_UNLK      4
`define WARF_WCS_RSTE      3
`define WARF_WCS_PLO_HI    2
`define WARF_WCS_PLO_LO    0
`define WARF_WCS_RESET     8'h00
`define WARF_SEL_RESET     4'h0

// ==========================================================
// timing
`define WARF_UNLOCK_CYC    3'h4
`define WARF_BASE_CYC      21'h000800
`define WARF_SEL_MAX       4'h9
`define WARF_CLK_KHZ       100000
`define WARF_OSC_KHZ       128
`define WARF_SYNC_RESET    4'h9

`endif

// ==== warf_monitor.sv ====
`timescale 1ns/1ps

// ========
// port checks of the watchdog block
module warf_monitor
(
    input wire       clk,
    input wire       rst,
    input wire [7:0] bus_addr,
    input wire       bus_io,
    input wire       bus_rd,
    input wire [7:0] bus_rdata,
    input wire       wd_irq_ack,
    input wire       core_irq_enable,
    input wire       wd_always_on_fuse,
    input wire       wd_irq_req,
    input wire       wd_sys_reset
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire rd_sts = bus_rd && (bus_io ? bus_addr == 8'h34 : bus_addr == 8'h54);
    wire rd_ctl = bus_rd && !bus_io && bus_addr == 8'h60;

    chk_pulse_single: assert property (
        wd_sys_reset |=> !wd_sys_reset)
        else $error("system reset pulse longer than one cycle");
    chk_req_global: assert property (
        wd_irq_req |-> core_irq_enable)
        else $error("interrupt request without global enable");
    chk_req_flag_set: assert property (
        rd_ctl && wd_irq_req && !wd_irq_ack |=> bus_rdata[7:6] == 2'b11)
        else $error("interrupt request without flag and enable");
    chk_ack_drops_req: assert property (
        wd_irq_ack |=> !wd_irq_req)
        else $error("request stays after vector execution");
    chk_sts_upper_zero: assert property (
        rd_sts |=> bus_rdata[7:4] == 4'h0)
        else $error("status upper bits not zero");
    chk_unmapped_zero: assert property (
        bus_rd && !rd_sts && !rd_ctl |=> bus_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_holds: assert property (
        !bus_rd |=> $stable(bus_rdata))
        else $error("read data changed without a read");
    chk_fuse_forces: assert property (
        !wd_always_on_fuse [*4] ##0 rd_ctl |=> bus_rdata[3] && !bus_rdata[6])
        else $error("fuse does not force reset mode");

    cover property (wd_sys_reset);
    cover property (wd_irq_req ##1 wd_irq_ack);
    cover property (rd_ctl && !wd_always_on_fuse);
endmodule // warf_monitor

bind warf_top warf_monitor warf_monitor_inst (.clk, .rst, .bus_addr, .bus_io,
    .bus_rd, .bus_rdata, .wd_irq_ack, .core_irq_enable, .wd_always_on_fuse,
    .wd_irq_req, .wd_sys_reset);

// ==== warf_sync.v ====
`timescale 1ns/1ps

// ==========================================================
// two-stage synchroniser for asynchronous levels
module warf_sync
#(
    parameter       W       = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
)
(
    input  wire         clk,
    input  wire         rst,
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);

    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end
        else
        begin
            meta_q <= din;
            sync_q <= meta_q;
        end
    end

    assign dout = sync_q;

endmodule // warf_sync

// ==== warf_tick.v ====
`timescale 1ns/1ps

// ==========================================================
// one-cycle enable at the watchdog oscillator rate
module warf_tick
#(
    parameter DIV = 781
)
(
    input  wire clk,
    input  wire rst,
    output wire tick
);

    reg [15:0] div_q;
    wire       wrap;

    // divide ratio truncates, so the tick runs slightly fast
    assign wrap = (div_q == DIV[15:0] - 16'h0001);

    always @(posedge clk or posedge rst)
    begin
        if (rst)
            div_q <= 16'h0000;
        else if (wrap)
            div_q <= 16'h0000;
        else
            div_q <= div_q + 16'h0001;
    end

    assign tick = wrap;

endmodule // warf_tick

// ==== warf_top.v ====
`timescale 1ns/1ps
`include "warf_map.vh"

// Contract
// - watchdog reset sets status bit 3; power-on or zero write clears
// - brown-out reset sets status bit 2; power-on or zero write clears
// - pin reset sets status bit 1; power-on or zero write clears
// - power-on sets status bit 0; only a zero write clears it
// - status register at data 0x54 and at I/O 0x34
// - time-out in interrupt operation sets control bit 7
// - interrupt flag clears on vector execution or on writing one
// - interrupt requested only when flag, enable and global enable set
// - combined mode: vector clears flag and enable, leaving reset mode
// - combined mode: unserviced flag at next time-out causes reset
// - fuse unprogrammed: reset and interrupt enables select the mode
// - fuse programmed: always system reset mode
// - clearing reset enable or period change needs unlock; unlock 4 cycles
// - reset enable forced on while watchdog reset flag is set
// - time-out is 2048 shifted by period code, up to code 1001
// - watchdog stays enabled after a watchdog reset
// - counter counts 128 kHz ticks and restarts on restart strobe
// - reset-mode time-out gives a one-cycle system reset pulse
module warf_top
#(
    parameter CLK_KHZ = `WARF_CLK_KHZ,
    parameter OSC_KHZ = `WARF_OSC_KHZ
)
(
    input  wire       clk,
    input  wire       rst,
    input  wire [7:0] bus_addr,
    input  wire       bus_io,
    input  wire       bus_wr,
    input  wire       bus_rd,
    input  wire [7:0] bus_wdata,
    output wire [7:0] bus_rdata,
    input  wire       wd_restart,
    input  wire       wd_irq_ack,
    input  wire       core_irq_enable,
    input  wire       wd_always_on_fuse,
    input  wire       poweron_in,
    input  wire       brownout_in,
    input  wire       pin_reset_n,
    output wire       wd_irq_req,
    output wire       wd_sys_reset
);

    localparam OSC_DIV = CLK_KHZ / OSC_KHZ;

    // ==========================================================
    // input synchronisers and oscillator tick
    wire [3:0]  sync_out;
    wire        fuse_s;
    wire        pwron_s;
    wire        brown_s;
    wire        pin_n_s;
    wire        osc_tick;

    warf_sync
    #(
        .W       (4),
        .RST_VAL (`WARF_SYNC_RESET)
    )
    u_sync
    (
        .clk  (clk),
        .rst  (rst),
        .din  ({wd_always_on_fuse, poweron_in, brownout_in, pin_reset_n}),
        .dout (sync_out)
    );

    assign fuse_s  = sync_out[3];
    assign pwron_s = sync_out[2];
    assign brown_s = sync_out[1];
    assign pin_n_s = sync_out[0];

    warf_tick
    #(
        .DIV (OSC_DIV)
    )
    u_tick
    (
        .clk  (clk),
        .rst  (rst),
        .tick (osc_tick)
    );

    // ==========================================================
    // state
    reg         fl_wdog_q;
    reg         fl_brown_q;
    reg         fl_pin_q;
    reg         fl_pwron_q;
    reg         irqf_q;
    reg         irqe_q;
    reg         unlk_q;
    reg  [2:0]  unlk_cnt_q;
    reg         rste_q;
    reg  [3:0]  sel_q;
    reg  [20:0] cnt_q;
    reg         sys_rst_q;
    reg  [7:0]  rdata_q;

    // ==========================================================
    // register decode
    wire        hit_rcs;
    wire        hit_wcs;
    wire        wr_rcs;
    wire        wr_wcs;

    assign hit_rcs = bus_io ? (bus_addr == `WARF_RCS_IO_OFS)
                            : (bus_addr == `WARF_RCS_DATA_OFS);
    // the control register lies above the I/O window, data space only
    assign hit_wcs = ~bus_io & (bus_addr == `WARF_WCS_DATA_OFS);
    assign wr_rcs  = bus_wr & hit_rcs;
    assign wr_wcs  = bus_wr & hit_wcs;

    // ==========================================================
    // mode selection
    wire        fuse_prog;
    wire        sys_hold;
    wire        rste_eff;
    wire        irqe_eff;
    wire        running;
    wire [3:0]  sel_eff;
    wire [20:0] limit;
    wire        timeout;
    wire        irq_to;
    wire        rst_to;

    // the fuse passes the synchroniser, so a change takes effect two
    // clocks later; the stored enables keep their values and simply
    // stop mattering while the fuse is programmed
    assign fuse_prog = ~fuse_s;
    assign sys_hold  = pwron_s | brown_s | ~pin_n_s;

    assign rste_eff = rste_q | fl_wdog_q | fuse_prog;
    assign irqe_eff = irqe_q & ~fuse_prog;
    assign running  = rste_eff | irqe_eff;

    assign sel_eff = (sel_q > `WARF_SEL_MAX) ? `WARF_SEL_MAX
                                             : sel_q;
    assign limit   = `WARF_BASE_CYC << sel_eff;
    assign timeout = osc_tick & running
                   & (cnt_q == limit - 21'h000001);

    // first time-out in combined mode only flags; a pending flag resets
    assign irq_to = timeout & irqe_eff
                  & ~(rste_eff & irqf_q);
    assign rst_to = timeout & rste_eff
                  & (~irqe_eff | irqf_q);

    // ==========================================================
    // watchdog counter
    // the counter runs only while a mode is selected; shortening the
    // period mid-count lets it run past the new limit until it wraps,
    // which is why software restarts it before a period change
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt_q <= 21'h000000;
        else if (sys_hold | sys_rst_q | wd_restart | timeout | ~running)
            cnt_q <= 21'h000000;
        else if (osc_tick)
            cnt_q <= cnt_q + 21'h000001;
    end

    // ==========================================================
    // system reset pulse
    // registered so the pulse is glitch free and exactly one clock wide
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            sys_rst_q <= 1'b0;
        else
            sys_rst_q <= rst_to;
    end

    assign wd_sys_reset = sys_rst_q;

    // ==========================================================
    // reset cause flags
    // a flag set in the cycle of a zero write stays set
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fl_wdog_q  <= 1'b0;
            fl_brown_q <= 1'b0;
            fl_pin_q   <= 1'b0;
            fl_pwron_q <= 1'b0;
        end
        else if (pwron_s)
        begin
            fl_wdog_q  <= 1'b0;
            fl_brown_q <= 1'b0;
            fl_pin_q   <= 1'b0;
            fl_pwron_q <= 1'b1;
        end
        else
        begin
            fl_wdog_q  <= sys_rst_q
                        | (fl_wdog_q
                        & ~(wr_rcs & ~bus_wdata[`WARF_RCS_WDOG]));
            fl_brown_q <= brown_s
                        | (fl_brown_q
                        & ~(wr_rcs & ~bus_wdata[`WARF_RCS_BROWN]));
            fl_pin_q   <= ~pin_n_s
                        | (fl_pin_q
                        & ~(wr_rcs & ~bus_wdata[`WARF_RCS_PIN]));
            fl_pwron_q <= fl_pwron_q
                        & ~(wr_rcs & ~bus_wdata[`WARF_RCS_PWRON]);
        end
    end

    // ==========================================================
    // change unlock window
    wire        unlk_start;

    assign unlk_start = wr_wcs & bus_wdata[`WARF_WCS_UNLK]
                      & bus_wdata[`WARF_WCS_RSTE];

    // the window counts system clocks, not oscillator ticks, so its
    // length does not depend on the divider setting; a second unlocking
    // write inside the window starts it afresh

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            unlk_q     <= 1'b0;
            unlk_cnt_q <= 3'h0;
        end
        else if (sys_hold | sys_rst_q)
        begin
            unlk_q     <= 1'b0;
            unlk_cnt_q <= 3'h0;
        end
        else if (unlk_start)
        begin
            unlk_q     <= 1'b1;
            unlk_cnt_q <= `WARF_UNLOCK_CYC;
        end
        else if (unlk_cnt_q != 3'h0)
        begin
            unlk_cnt_q <= unlk_cnt_q - 3'h1;
            if (unlk_cnt_q == 3'h1)
                unlk_q <= 1'b0;
        end
    end

    // ==========================================================
    // reset enable and period select
    // an unlocking write made with no window open never changes the period,
    // so the old setting survives the first step of the sequence
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rste_q <= 1'b0;
            sel_q  <= `WARF_SEL_RESET;
        end
        else if (sys_hold | sys_rst_q)
        begin
            rste_q <= 1'b0;
            sel_q  <= `WARF_SEL_RESET;
        end
        else
        begin
            if (fl_wdog_q)
                rste_q <= 1'b1;
            else if (wr_wcs & bus_wdata[`WARF_WCS_RSTE])
                rste_q <= 1'b1;
            else if (wr_wcs & unlk_q)
                rste_q <= 1'b0;
            if (wr_wcs & unlk_q)
                sel_q <= {bus_wdata[`WARF_WCS_PMSB],
                          bus_wdata[`WARF_WCS_PLO_HI:`WARF_WCS_PLO_LO]};
        end
    end

    // ==========================================================
    // interrupt enable and flag
    // the vector clears the enable only while reset is enabled too, so
    // plain interrupt mode survives the servicing of its own interrupt
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irqe_q <= 1'b0;
            irqf_q <= 1'b0;
        end
        else if (sys_hold | sys_rst_q)
        begin
            irqe_q <= 1'b0;
            irqf_q <= 1'b0;
        end
        else
        begin
            if (wd_irq_ack & rste_eff)
                irqe_q <= 1'b0;
            else if (wr_wcs)
                irqe_q <= bus_wdata[`WARF_WCS_IRQE];
            // a time-out in the cycle of a clear keeps the flag set
            irqf_q <= irq_to
                    | (irqf_q & ~wd_irq_ack
                    & ~(wr_wcs & bus_wdata[`WARF_WCS_IRQF]));
        end
    end

    assign wd_irq_req = irqf_q & irqe_eff & core_irq_enable;

    // ==========================================================
    // read data
    wire [7:0] rcs_val;
    wire [7:0] wcs_val;

    // other addresses read zero rather than the last value, so a stray
    // read cannot leak a stale register
    assign rcs_val = {`WARF_RCS_RESET, fl_wdog_q, fl_brown_q,
                      fl_pin_q, fl_pwron_q};
    assign wcs_val = {irqf_q, irqe_eff, sel_q[3], unlk_q,
                      rste_eff, sel_q[2:0]};

    always @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata_q <= `WARF_WCS_RESET;
        else if (bus_rd & hit_rcs)
            rdata_q <= rcs_val;
        else if (bus_rd & hit_wcs)
            rdata_q <= wcs_val;
        else if (bus_rd)
            rdata_q <= `WARF_WCS_RESET;
    end

    assign bus_rdata = rdata_q;

endmodule // warf_top

// ==== watchdog_and_reset_flags_bench.sv ====
`timescale 1ns/1ps

// ========
// register-level bench, one oscillator tick per clock
module watchdog_and_reset_flags_bench;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [7:0] bus_addr = 8'h00;
    logic       bus_io = 1'b0;
    logic       bus_wr = 1'b0;
    logic       bus_rd = 1'b0;
    logic [7:0] bus_wdata = 8'h00;
    logic [7:0] bus_rdata;
    logic       wd_restart = 1'b0;
    logic       wd_irq_ack = 1'b0;
    logic       core_irq_enable = 1'b0;
    logic       wd_always_on_fuse = 1'b1;
    logic       poweron_in = 1'b0;
    logic       brownout_in = 1'b0;
    logic       pin_reset_n = 1'b1;
    logic       wd_irq_req;
    logic       wd_sys_reset;
    integer     err_count = 0;
    integer     n_compared = 0;

    warf_top #(.CLK_KHZ(128), .OSC_KHZ(128)) warf_top_inst (.clk, .rst,
        .bus_addr, .bus_io, .bus_wr, .bus_rd, .bus_wdata, .bus_rdata,
        .wd_restart, .wd_irq_ack, .core_irq_enable, .wd_always_on_fuse,
        .poweron_in, .brownout_in, .pin_reset_n, .wd_irq_req, .wd_sys_reset);

    initial forever #5 clk = ~clk;

    task finish_test;
        $display("compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task chk(input [15:0] got, input [15:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input [7:0] a, input io, input [7:0] d);
        @(negedge clk);
        bus_addr = a;
        bus_io = io;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(negedge clk);
        bus_wr = 1'b0;
    endtask

    task rd(input [7:0] a, input io, input [7:0] exp);
        @(negedge clk);
        bus_addr = a;
        bus_io = io;
        bus_rd = 1'b1;
        @(negedge clk);
        bus_rd = 1'b0;
        chk(bus_rdata, exp);
    endtask

    // one-cycle restart (0) or vector execution (1)
    task strobe(input ack);
        @(negedge clk);
        wd_irq_ack = ack;
        wd_restart = !ack;
        @(negedge clk);
        {wd_irq_ack, wd_restart} = 2'b00;
    endtask

    // reset source: 0 power-on, 1 pin, 2 brown-out
    task src(input [1:0] k);
        @(negedge clk);
        {brownout_in, poweron_in, pin_reset_n} = {k == 2, k == 0, k != 1};
        repeat (4) @(negedge clk);
        {brownout_in, poweron_in, pin_reset_n} = 3'b001;
        repeat (4) @(negedge clk);
    endtask

    // expect interrupt request or reset pulse about lo cycles from now
    task wait_out(input integer lo, input irq);
        integer n;
        n = 0;
        while ((irq ? wd_irq_req : wd_sys_reset) !== 1'b1 && n < lo + 20)
        begin
            @(negedge clk);
            n = n + 1;
        end
        chk(n > lo - 20 && n < lo + 20, 1'b1);
        if (n >= lo + 20)
            finish_test;
    endtask

    // clear the watchdog flag, then reset enable through the unlock window
    task wd_off;
        wr(8'h54, 1'b0, 8'h00);
        wr(8'h60, 1'b0, 8'h18);
        wr(8'h60, 1'b0, 8'h00);
        repeat (2) @(negedge clk);
    endtask

    initial
    begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        rd(8'h54, 1'b0, 8'h00);
        rd(8'h60, 1'b0, 8'h00);
        rd(8'h70, 1'b0, 8'h00);
        rd(8'h40, 1'b1, 8'h00);
        src(0);
        rd(8'h54, 1'b0, 8'h01);
        rd(8'h34, 1'b1, 8'h01);
        src(1);
        rd(8'h34, 1'b1, 8'h03);
        src(2);
        rd(8'h54, 1'b0, 8'h07);
        src(0);
        rd(8'h54, 1'b0, 8'h01);
        wr(8'h34, 1'b1, 8'h00);
        rd(8'h54, 1'b0, 8'h00);
        wr(8'h60, 1'b0, 8'h08);
        strobe(0);
        wait_out(2048, 0);
        repeat (3) @(negedge clk);
        rd(8'h54, 1'b0, 8'h08);
        wr(8'h60, 1'b0, 8'h18);
        wr(8'h60, 1'b0, 8'h00);
        repeat (2) @(negedge clk);
        rd(8'h60, 1'b0, 8'h08);
        wd_off;
        rd(8'h60, 1'b0, 8'h00);
        wr(8'h60, 1'b0, 8'h18);
        repeat (6) @(negedge clk);
        wr(8'h60, 1'b0, 8'h01);
        rd(8'h60, 1'b0, 8'h08);
        strobe(0);
        wr(8'h60, 1'b0, 8'h18);
        wr(8'h60, 1'b0, 8'h09);
        repeat (2) @(negedge clk);
        rd(8'h60, 1'b0, 8'h09);
        strobe(0);
        wait_out(4096, 0);
        wd_off;
        core_irq_enable = 1'b1;
        wr(8'h60, 1'b0, 8'h40);
        strobe(0);
        wait_out(2048, 1);
        rd(8'h60, 1'b0, 8'hc0);
        core_irq_enable = 1'b0;
        @(negedge clk);
        chk(wd_irq_req, 1'b0);
        core_irq_enable = 1'b1;
        wr(8'h60, 1'b0, 8'hc0);
        rd(8'h60, 1'b0, 8'h40);
        strobe(0);
        wait_out(2048, 1);
        strobe(1);
        rd(8'h60, 1'b0, 8'h40);
        wr(8'h60, 1'b0, 8'h48);
        strobe(0);
        wait_out(2048, 1);
        strobe(1);
        rd(8'h60, 1'b0, 8'h08);
        wd_off;
        wr(8'h60, 1'b0, 8'h48);
        strobe(0);
        wait_out(2048, 1);
        wait_out(2048, 0);
        repeat (2) @(negedge clk);
        rd(8'h54, 1'b0, 8'h08);
        wd_off;
        wd_always_on_fuse = 1'b0;
        repeat (4) @(negedge clk);
        rd(8'h60, 1'b0, 8'h08);
        strobe(0);
        wait_out(2048, 0);
        wd_always_on_fuse = 1'b1;
        wd_off;
        finish_test;
    end
endmodule // watchdog_and_reset_flags_bench
